/* File: include/cfg_loader_pkg.sv */
/*
 * Shared constants and types for the configuration loader front end:
 * register map, field positions, reset values, stream coding and states.
 * Assumes a 50 MHz system clock and a byte-wide configuration data link.
 */
package cfg_loader_pkg;

    // ************************************************************
    // Clock and widths
    // ************************************************************
    localparam int CLK_MHZ      = 50;
    localparam int LINK_W       = 8;
    localparam int FRAME_W      = 32;
    localparam int FIFO_DEPTH   = 16;
    localparam int BYTE_BITS    = 8;
    localparam int PORCNT_W     = 32;

    // ************************************************************
    // Register map (byte addresses on the Avalon slave)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_LEN    = 8'h08;
    localparam logic [7:0] OFS_COUNT  = 8'h0c;

    localparam int CTRL_COMPRESS_BIT = 0;
    localparam int STAT_STATE_LSB    = 0;
    localparam int STAT_FAST_BIT     = 4;
    localparam int STAT_EMPTY_BIT    = 5;
    localparam int STAT_OVF_BIT      = 6;

    // Expected uncompressed length of the smallest device, in bits.
    localparam logic [31:0] LEN_RESET = 32'h002cec58;

    // ************************************************************
    // Compressed stream coding
    // ************************************************************
    localparam logic [7:0] ESC_BYTE  = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam int         RUN_W     = 2;

    // ************************************************************
    // Scheme-select patterns that choose the fast power-on delay
    // ************************************************************
    localparam logic [2:0] SCH_FAST_A = 3'h5;
    localparam logic [2:0] SCH_FAST_B = 3'h3;
    localparam logic [2:0] SCH_FAST_C = 3'h4;
    localparam logic [2:0] SCH_FAST_D = 3'h6;

    // Supply monitor bit positions.
    localparam int SUP_CORE = 0;
    localparam int SUP_PLL  = 1;
    localparam int SUP_IO   = 2;

    typedef enum logic [2:0] {
        ST_POR_WAIT,
        ST_POR_DELAY,
        ST_RESET,
        ST_CONFIG,
        ST_DONE,
        ST_ERROR
    } ld_state_t;

endpackage

/* File: rtl/cfg_word_fifo.sv */
/*
 * Synchronous word FIFO with valid/ready on both sides.
 * Assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module cfg_word_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         sys_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } fifo_st_t;

    fifo_st_t r_reg;
    fifo_st_t r_next;
    logic     full;
    logic     empty;

    assign full        = (r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
    assign empty       = (r_reg.wp == r_reg.rp);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = r_reg.mem[r_reg.rp[AW-1:0]];

    always_comb begin
        r_next = r_reg;
        if (in_valid_i && !full) begin
            r_next.mem[r_reg.wp[AW-1:0]] = in_data_i;
            r_next.wp = (AW+1)'(r_reg.wp + 1'b1);
        end
        if (out_ready_i && !empty) begin
            r_next.rp = (AW+1)'(r_reg.rp + 1'b1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

/* File: rtl/cfg_loader.sv */
/*
 * Configuration loader front end: power-on reset gate with brown-out watch,
 * request-line reset, on-the-fly decompression of the configuration stream,
 * word packing into a FIFO toward the frame writer, and an Avalon-MM slave.
 * Assumes supply monitors, scheme pins, request line, data clock and data
 * arrive asynchronously, and that the data clock is slower than 4 system
 * clocks per period so each edge can be seen after synchronisation.
 */
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps

// What this block does
// - With compression on, the stream is expanded as it arrives and goes straight to the cells.
// - Expansion of one input byte finishes before the next byte can arrive, so the link is never slowed.
// - Each device takes compressed or raw data according to its own compression setting.
// - After power-up the device stays in reset with status held low until all supplies pass the trip point.
// - Once powered, a drop of the core or PLL supply returns the device to the power-on wait state (ST_POR_WAIT).
// - The scheme pins sampled at power-up pick the fast or the standard power-on delay.
// - The uncompressed length is fixed per device and serves as the expected total of written bits.
// - With compression on, completion is judged on expanded bits, never on the incoming length.
// - The device stays in reset while the request line is low; the host pulses it low at least 500 ns.
// - When the request line goes high the device leaves reset, releases status, then takes data.
// - On a data frame error the status line is driven low and the done flag stays low.
module cfg_loader #(
    parameter int POR_FAST_US = 3000,
    parameter int POR_STD_US  = 50000
) (
    input  wire logic                               sys_clk_i,
    input  wire logic                               resetn_i,
    input  wire logic [7:0]                         avs_address_i,
    input  wire logic                               avs_read_i,
    input  wire logic                               avs_write_i,
    input  wire logic [31:0]                        avs_writedata_i,
    input  wire logic [3:0]                         avs_byteenable_i,
    output logic [31:0]                             avs_readdata_o,
    output logic                                    avs_waitrequest_o,
    input  wire logic                               supply_core_ok_i,
    input  wire logic                               supply_pll_ok_i,
    input  wire logic                               supply_io_ok_i,
    input  wire logic [2:0]                         scheme_select_pins_i,
    input  wire logic                               config_request_low_i,
    input  wire logic                               config_data_clock_i,
    input  wire logic [cfg_loader_pkg::LINK_W-1:0]  config_data_i,
    output logic                                    config_status_low_o,
    output logic                                    config_status_low_oe_o,
    output logic                                    load_complete_flag_o,
    output logic                                    load_complete_flag_oe_o,
    output logic                                    device_reset_o,
    output logic [cfg_loader_pkg::FRAME_W-1:0]      frame_data_o,
    output logic                                    frame_valid_o,
    input  wire logic                               frame_ready_i
);
    localparam int LW    = cfg_loader_pkg::LINK_W;
    localparam int FW    = cfg_loader_pkg::FRAME_W;
    localparam int LANES = FW / LW;
    localparam int LN_W  = $clog2(LANES);
    localparam int RW    = cfg_loader_pkg::RUN_W;
    localparam logic [LN_W-1:0] LAST_LANE = LN_W'(LANES - 1);
    localparam logic [31:0] FAST_LIM = 32'(POR_FAST_US * cfg_loader_pkg::CLK_MHZ);
    localparam logic [31:0] STD_LIM  = 32'(POR_STD_US * cfg_loader_pkg::CLK_MHZ);
    localparam logic [31:0] BYTE_INC = 32'(cfg_loader_pkg::BYTE_BITS);

    typedef struct packed {
        logic                      req_m;
        logic                      req_s;
        logic [2:0]                sup_m;
        logic [2:0]                sup_s;
        logic [2:0]                sch_m;
        logic [2:0]                sch_s;
        logic                      config_data_clock_m;
        logic                      config_data_clock_s;
        logic                      config_data_clock_prev;
        logic [LW-1:0]             dat_m;
        logic [LW-1:0]             dat_s;
        cfg_loader_pkg::ld_state_t state;
        logic                      fast_sel;
        logic [31:0]               por_cnt;
        logic                      compress_en;
        logic [31:0]               expect_bits;
        logic [31:0]               bit_cnt;
        logic                      overflow;
        logic                      esc_pend;
        logic [RW-1:0]             run_left;
        logic [FW-1:0]             pack;
        logic [LN_W-1:0]           pack_n;
        logic                      push_vld;
        logic [FW-1:0]             push_data;
        logic                      ack;
        logic [31:0]               rdata;
    } ld_st_t;

    ld_st_t r_reg;
    ld_st_t r_next;
    logic   fifo_in_ready;
    logic   fifo_out_valid;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic is_fast_scheme(input logic [2:0] pins);
        is_fast_scheme = (pins == cfg_loader_pkg::SCH_FAST_A) ||
                         (pins == cfg_loader_pkg::SCH_FAST_B) ||
                         (pins == cfg_loader_pkg::SCH_FAST_C) ||
                         (pins == cfg_loader_pkg::SCH_FAST_D);
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge_be = res;
    endfunction

    // ************************************************************
    // Word FIFO toward the frame writer
    // ************************************************************
    cfg_word_fifo #(
        .W     (FW),
        .DEPTH (cfg_loader_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (r_reg.push_vld),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (r_reg.push_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (frame_ready_i),
        .out_data_o  (frame_data_o)
    );

    assign frame_valid_o = fifo_out_valid;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic          config_data_clock_rise;
        logic          sup_all;
        logic          brownout;
        logic          emit;
        logic [LW-1:0] emit_byte;
        logic          bus_req;
        logic [31:0]   lim;
        logic [31:0]   next_bits;

        r_next    = r_reg;
        config_data_clock_rise = r_reg.config_data_clock_s & ~r_reg.config_data_clock_prev;
        sup_all   = &r_reg.sup_s;
        brownout  = ~(r_reg.sup_s[cfg_loader_pkg::SUP_CORE] & r_reg.sup_s[cfg_loader_pkg::SUP_PLL]);
        emit      = 1'b0;
        emit_byte = cfg_loader_pkg::FILL_BYTE;
        bus_req   = avs_read_i | avs_write_i;
        lim       = r_reg.fast_sel ? FAST_LIM : STD_LIM;
        next_bits = r_reg.bit_cnt + BYTE_INC;

        r_next.req_m     = config_request_low_i;
        r_next.req_s     = r_reg.req_m;
        r_next.sup_m     = {supply_io_ok_i, supply_pll_ok_i, supply_core_ok_i};
        r_next.sup_s     = r_reg.sup_m;
        r_next.sch_m     = scheme_select_pins_i;
        r_next.sch_s     = r_reg.sch_m;
        r_next.config_data_clock_m    = config_data_clock_i;
        r_next.config_data_clock_s    = r_reg.config_data_clock_m;
        r_next.config_data_clock_prev = r_reg.config_data_clock_s;
        r_next.dat_m     = config_data_i;
        r_next.dat_s     = r_reg.dat_m;
        r_next.push_vld  = 1'b0;

        case (r_reg.state)
            cfg_loader_pkg::ST_POR_WAIT: begin
                r_next.por_cnt = '0;
                if (sup_all) begin
                    r_next.fast_sel = is_fast_scheme(r_reg.sch_s);
                    r_next.state    = cfg_loader_pkg::ST_POR_DELAY;
                end
            end
            cfg_loader_pkg::ST_POR_DELAY: begin
                if (!sup_all) begin
                    r_next.state = cfg_loader_pkg::ST_POR_WAIT;
                end else if (r_reg.por_cnt >= lim - 32'h1) begin
                    r_next.state = cfg_loader_pkg::ST_RESET;
                end else begin
                    r_next.por_cnt = r_reg.por_cnt + 32'h1;
                end
            end
            cfg_loader_pkg::ST_RESET: begin
                r_next.bit_cnt  = '0;
                r_next.pack     = '0;
                r_next.pack_n   = '0;
                r_next.esc_pend = 1'b0;
                r_next.run_left = '0;
                r_next.overflow = 1'b0;
                if (r_reg.req_s) begin
                    r_next.state = cfg_loader_pkg::ST_CONFIG;
                end
            end
            cfg_loader_pkg::ST_CONFIG: begin
                // A run of fill bytes starts in the cycle its count arrives and lasts at
                // most four cycles, which is the shortest data clock period that the
                // synchroniser can resolve, so no input byte ever waits.
                if (config_data_clock_rise) begin
                    if (!r_reg.compress_en) begin
                        emit      = 1'b1;
                        emit_byte = r_reg.dat_s;
                    end else if (r_reg.esc_pend) begin
                        r_next.esc_pend = 1'b0;
                        r_next.run_left = r_reg.dat_s[RW-1:0];
                        emit            = 1'b1;
                    end else if (r_reg.dat_s == cfg_loader_pkg::ESC_BYTE) begin
                        r_next.esc_pend = 1'b1;
                    end else begin
                        emit      = 1'b1;
                        emit_byte = r_reg.dat_s;
                    end
                end else if (r_reg.run_left != '0) begin
                    emit            = 1'b1;
                    r_next.run_left = RW'(r_reg.run_left - 1'b1);
                end
                if (emit) begin
                    r_next.pack[r_reg.pack_n*LW +: LW] = emit_byte;
                    r_next.bit_cnt = next_bits;
                    r_next.pack_n  = LN_W'(r_reg.pack_n + 1'b1);
                    if (r_reg.pack_n == LAST_LANE || next_bits >= r_reg.expect_bits) begin
                        r_next.push_vld  = 1'b1;
                        r_next.push_data = r_next.pack;
                        r_next.pack      = '0;
                        r_next.pack_n    = '0;
                    end
                    if (next_bits >= r_reg.expect_bits) begin
                        r_next.state = cfg_loader_pkg::ST_DONE;
                    end
                end
            end
            cfg_loader_pkg::ST_DONE: begin
            end
            cfg_loader_pkg::ST_ERROR: begin
            end
            default: begin
                r_next.state = cfg_loader_pkg::ST_POR_WAIT;
            end
        endcase

        // A word refused by a full FIFO is a lost frame: the load cannot complete.
        if (r_reg.push_vld && !fifo_in_ready) begin
            r_next.overflow = 1'b1;
            r_next.state    = cfg_loader_pkg::ST_ERROR;
        end

        if (r_reg.state != cfg_loader_pkg::ST_POR_WAIT &&
            r_reg.state != cfg_loader_pkg::ST_POR_DELAY) begin
            if (brownout) begin
                r_next.state = cfg_loader_pkg::ST_POR_WAIT;
            end else if (!r_reg.req_s) begin
                r_next.state = cfg_loader_pkg::ST_RESET;
            end
        end

        // ************************************************************
        // Avalon-MM slave: one wait cycle, then the access completes
        // ************************************************************
        r_next.ack = bus_req & ~r_reg.ack;
        if (bus_req && !r_reg.ack && avs_read_i) begin
            if (avs_address_i == cfg_loader_pkg::OFS_CTRL) begin
                r_next.rdata = '0;
                r_next.rdata[cfg_loader_pkg::CTRL_COMPRESS_BIT] = r_reg.compress_en;
            end else if (avs_address_i == cfg_loader_pkg::OFS_STATUS) begin
                r_next.rdata = '0;
                r_next.rdata[cfg_loader_pkg::STAT_STATE_LSB +: 3] = r_reg.state;
                r_next.rdata[cfg_loader_pkg::STAT_FAST_BIT]  = r_reg.fast_sel;
                r_next.rdata[cfg_loader_pkg::STAT_EMPTY_BIT] = ~fifo_out_valid;
                r_next.rdata[cfg_loader_pkg::STAT_OVF_BIT]   = r_reg.overflow;
            end else if (avs_address_i == cfg_loader_pkg::OFS_LEN) begin
                r_next.rdata = r_reg.expect_bits;
            end else if (avs_address_i == cfg_loader_pkg::OFS_COUNT) begin
                r_next.rdata = r_reg.bit_cnt;
            end else begin
                r_next.rdata = '0;
            end
        end
        // Settings are frozen while a load is in flight so a stream never
        // switches coding or target length halfway.
        if (avs_write_i && r_reg.ack && r_reg.state != cfg_loader_pkg::ST_CONFIG) begin
            if (avs_address_i == cfg_loader_pkg::OFS_CTRL) begin
                if (avs_byteenable_i[0]) begin
                    r_next.compress_en = avs_writedata_i[cfg_loader_pkg::CTRL_COMPRESS_BIT];
                end
            end else if (avs_address_i == cfg_loader_pkg::OFS_LEN) begin
                r_next.expect_bits = merge_be(r_reg.expect_bits, avs_writedata_i, avs_byteenable_i);
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r_reg             <= '0;
            r_reg.state       <= cfg_loader_pkg::ST_POR_WAIT;
            r_reg.expect_bits <= cfg_loader_pkg::LEN_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~r_reg.ack;
    assign avs_readdata_o    = r_reg.rdata;

    // Open-drain pins only ever pull low; the enable carries the level.
    assign config_status_low_o    = 1'b0;
    assign config_status_low_oe_o = (r_reg.state != cfg_loader_pkg::ST_CONFIG) &&
                                    (r_reg.state != cfg_loader_pkg::ST_DONE);
    assign load_complete_flag_o    = 1'b0;
    assign load_complete_flag_oe_o = ~((r_reg.state == cfg_loader_pkg::ST_DONE) && ~fifo_out_valid);
    assign device_reset_o = (r_reg.state == cfg_loader_pkg::ST_POR_WAIT) ||
                            (r_reg.state == cfg_loader_pkg::ST_POR_DELAY) ||
                            (r_reg.state == cfg_loader_pkg::ST_RESET);
endmodule

/* File: sim/cfg_loader_assertions.sv */
/*
 * Port checker for the configuration loader front end.
 * Assumes it is bound to every cfg_loader instance and sees only its ports.
 */
`timescale 1ns/1ps
module cfg_loader_assertions (
    input  wire logic                                sys_clk_i,
    input  wire logic                                resetn_i,
    input  wire logic                                avs_read_i,
    input  wire logic                                avs_write_i,
    input  wire logic                                avs_waitrequest_o,
    input  wire logic                                supply_core_ok_i,
    input  wire logic                                config_request_low_i,
    input  wire logic                                config_status_low_oe_o,
    input  wire logic                                load_complete_flag_oe_o,
    input  wire logic                                device_reset_o,
    input  wire logic [cfg_loader_pkg::FRAME_W-1:0]  frame_data_o,
    input  wire logic                                frame_valid_o,
    input  wire logic                                frame_ready_i
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // Four cycles cover the two-flop synchroniser plus the state update.
    sequence req_held_low_s;
        !config_request_low_i [*4];
    endsequence
    sequence core_lost_s;
        !supply_core_ok_i [*4];
    endsequence
    one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("Bus request waited more than one cycle.");
    por_gate_a: assert property (device_reset_o |-> config_status_low_oe_o)
        else $error("Status released while the device is in reset.");
    core_loss_a: assert property (core_lost_s |-> device_reset_o)
        else $error("Core supply loss did not return to reset.");
    req_reset_a: assert property (req_held_low_s |-> device_reset_o && config_status_low_oe_o)
        else $error("Request line low did not hold the device in reset.");
    req_release_a: assert property ($fell(device_reset_o) |->
        $past(config_request_low_i, 2) && !config_status_low_oe_o)
        else $error("Reset left without request high.");
    error_done_a: assert property (config_status_low_oe_o && !device_reset_o
        |-> load_complete_flag_oe_o) else $error("Done released during a load error.");
    done_release_a: assert property (!load_complete_flag_oe_o
        |-> !config_status_low_oe_o && !frame_valid_o) else $error("Done released too early.");
    frame_hold_a: assert property (frame_valid_o && !frame_ready_i
        |=> device_reset_o || (frame_valid_o && $stable(frame_data_o)))
        else $error("Frame word changed while stalled.");
endmodule
bind cfg_loader cfg_loader_assertions cfg_loader_assertions_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .supply_core_ok_i(supply_core_ok_i), .config_request_low_i(config_request_low_i),
    .config_status_low_oe_o(config_status_low_oe_o), .device_reset_o(device_reset_o),
    .load_complete_flag_oe_o(load_complete_flag_oe_o), .frame_data_o(frame_data_o),
    .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i));

/* File: sim/cfg_stream_source.sv */
/*
 * Bitstream source standing in for a configuration memory or host.
 * Assumes the caller waits for each byte; the link clock stands still between bytes.
 */
`timescale 1ns/1ps
module cfg_stream_source (
    output logic       config_data_clock_o,
    output logic [7:0] config_data_o
);
    initial begin
        config_data_clock_o = 1'b0;
        config_data_o = 8'h00;
    end
    // Bytes follow each other with no pause; the device has no way to slow us.
    task automatic send(input logic [7:0] b);
        #3 config_data_o = b;
        #80 config_data_clock_o = 1'b1;
        #80 config_data_clock_o = 1'b0;
        // Stale data is inverted so a late sample cannot pass by luck.
        config_data_o = ~b;
    endtask
endmodule

/* File: sim/tb_top.sv */
/*
 * Bench for the configuration loader: bus accesses, supply and request sequencing,
 * raw, overflowing and compressed streams. Assumes the source model and checker.
 */
`timescale 1ns/1ps
module tb_top;
    logic        clk, rstn, rd, wr, core, pll, io, req, config_data_clock, wq, vld, rdy, st_oe, dn_oe, drst;
    logic [7:0]  adr, dat;
    logic [2:0]  sch;
    logic [31:0] wd, rdat, fdat, q;
    int          errors, num_checks, n;
    logic [31:0] words[$];
    logic [7:0]  cz[7] = '{8'h11, 8'h00, 8'h02, 8'h22, 8'h33, 8'h00, 8'h01};
    cfg_loader #(.POR_FAST_US(1), .POR_STD_US(2)) cfg_loader_inst (
        .sys_clk_i(clk), .resetn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .supply_core_ok_i(core),
        .supply_pll_ok_i(pll), .supply_io_ok_i(io), .scheme_select_pins_i(sch),
        .config_request_low_i(req), .config_data_clock_i(config_data_clock), .config_data_i(dat),
        .config_status_low_o(), .config_status_low_oe_o(st_oe), .load_complete_flag_o(),
        .load_complete_flag_oe_o(dn_oe), .device_reset_o(drst), .frame_data_o(fdat),
        .frame_valid_o(vld), .frame_ready_i(rdy));
    cfg_stream_source cfg_stream_source_inst (.config_data_clock_o(config_data_clock), .config_data_o(dat));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (vld === 1'b1 && rdy === 1'b1) words.push_back(fdat);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd <= ~w;
        wr <= w;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q & m, e);
    endtask
    task automatic wait_state(input logic [2:0] s);
        n = 0;
        do begin
            bus(1'b0, cfg_loader_pkg::OFS_STATUS, 32'h0);
            n++;
        end while (q[2:0] !== s && n < 400);
        check({29'h0, q[2:0]}, {29'h0, s});
    endtask
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        errors++;
        wrap_up();
    end
    initial begin
        {rstn, rd, wr, core, pll, io, req, adr, wd, errors, num_checks} = '0;
        sch = 3'h5;
        rdy = 1'b1;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdc(cfg_loader_pkg::OFS_LEN, 32'hffffffff, cfg_loader_pkg::LEN_RESET);
        rdc(8'h10, 32'hffffffff, 32'h0);
        {core, pll} <= 2'h3;
        repeat (10) @(posedge clk);
        rdc(cfg_loader_pkg::OFS_STATUS, 32'h7, 32'h0);
        check(st_oe, 32'h1);
        io <= 1'b1;
        wait_state(3'h2);
        check(n < 26, 32'h1);
        rdc(cfg_loader_pkg::OFS_STATUS, 32'h10, 32'h10);
        pll <= 1'b0;
        sch <= 3'h1;
        wait_state(3'h0);
        check(drst, 32'h1);
        pll <= 1'b1;
        wait_state(3'h2);
        check(n > 26, 32'h1);
        rdc(cfg_loader_pkg::OFS_STATUS, 32'h10, 32'h0);
        bus(1'b1, cfg_loader_pkg::OFS_LEN, 32'h40);
        bus(1'b1, cfg_loader_pkg::OFS_CTRL, 32'h0);
        req <= 1'b1;
        wait_state(3'h3);
        check(st_oe, 32'h0);
        for (int i = 1; i <= 8; i++) cfg_stream_source_inst.send(i[7:0]);
        @(posedge clk);
        wait_state(3'h4);
        check(words.pop_front(), 32'h04030201);
        check(words.pop_front(), 32'h08070605);
        check(dn_oe, 32'h0);
        req <= 1'b0;
        repeat (30) @(posedge clk);
        bus(1'b1, cfg_loader_pkg::OFS_LEN, 32'h1000);
        rdy <= 1'b0;
        req <= 1'b1;
        wait_state(3'h3);
        for (int i = 0; i < 68; i++) cfg_stream_source_inst.send(i[7:0]);
        @(posedge clk);
        wait_state(3'h5);
        check({st_oe, dn_oe}, 32'h3);
        rdc(cfg_loader_pkg::OFS_STATUS, 32'h40, 32'h40);
        req <= 1'b0;
        rdy <= 1'b1;
        repeat (30) @(posedge clk);
        words.delete();
        bus(1'b1, cfg_loader_pkg::OFS_CTRL, 32'h1);
        bus(1'b1, cfg_loader_pkg::OFS_LEN, 32'h40);
        req <= 1'b1;
        wait_state(3'h3);
        bus(1'b1, cfg_loader_pkg::OFS_LEN, 32'h8);
        rdc(cfg_loader_pkg::OFS_LEN, 32'hffffffff, 32'h40);
        foreach (cz[i]) cfg_stream_source_inst.send(cz[i]);
        @(posedge clk);
        wait_state(3'h4);
        check(words.pop_front(), 32'h00000011);
        check(words.pop_front(), 32'h00003322);
        rdc(cfg_loader_pkg::OFS_COUNT, 32'hffffffff, 32'h40);
        core <= 1'b0;
        wait_state(3'h0);
        check(drst, 32'h1);
        wrap_up();
    end
endmodule
